// file: include/wkint_defs.svh
`ifndef WKINT_DEFS_SVH
`define WKINT_DEFS_SVH
// Register byte addresses on APB
`define WKINT_A_FLAGS_ONE 12'h000
`define WKINT_A_FLAGS_TWO 12'h004
`define WKINT_A_WAKE_FLAGS 12'h008
`define WKINT_A_WAKE_EDGE 12'h00C
`define WKINT_A_REQ_EDGE 12'h010
`define WKINT_A_ENABLE_ONE 12'h014
`define WKINT_A_PIN_MODE 12'h018
`define WKINT_A_COND 12'h01C
`define WKINT_A_VECTOR 12'h020
// Field positions
`define WKINT_B_FIXED_ONE 5
`define WKINT_B_TFL 2
`define WKINT_B_TC 1
`define WKINT_B_EC 0
`define WKINT_B_WAKE_EN 5
`define WKINT_B_TFL_EN 2
`define WKINT_B_TC_EN 1
`define WKINT_B_EC_EN 0
`define WKINT_B_MASK 7
// Reset values
`define WKINT_RST_BYTE 8'h00
`define WKINT_RST_MASK 1'b1
// Vector numbers
`define WKINT_VEC_WAKE 8'h09
`define WKINT_VEC_REQ0 8'h04
`define WKINT_VEC_NONE 8'h00
`define WKINT_VEC_TFL 8'h0B
`define WKINT_VEC_TC 8'h0A
`define WKINT_VEC_EC 8'h0C
// Counter extremes
`define WKINT_CNT_MAX 8'hFF
`define WKINT_CNT_MIN 8'h00
`endif

// file: include/wkint_pkg.sv
package wkint_pkg;
   // Peripheral event inputs grouped
   typedef struct packed {
      logic [7:0] low_timer_counter;       // Low timer count
      logic [7:0] low_timer_compare_value; // Low timer compare value
      logic low_timer_8bit_mode;           // Low timer in 8-bit mode
      logic low_timer_tick;                // Counter just changed
      logic [7:0] updown_count;            // Up/down timer count
      logic updown_tick;                   // Counter just changed
      logic [7:0] event_count_high;        // Event counter high byte
      logic [7:0] event_count_low;         // Event counter low byte
      logic event_16bit_mode;              // Event counter 16-bit mode
      logic event_tick_high;               // High byte just changed
      logic event_tick_low;                // Low byte just changed
   } wkint_periph_s;
   typedef logic [7:0] wkint_byte_t;
endpackage

// file: core/wkint_edge_det.sv
`timescale 1ns/1ps
`include "wkint_defs.svh"
// Per-pin selectable edge detector
module wkint_edge_det
   import wkint_pkg::*;
#(
   parameter int N = 8
) (
   input wire logic clk_sys,          // System clock
   input wire logic rst_n,            // Async reset, active low
   input wire logic [N-1:0] pin,      // Pin levels
   input wire logic [N-1:0] rise_sel, // 1 rising, 0 falling
   input wire logic [N-1:0] active,   // Pin in interrupt function
   output logic [N-1:0] hit           // One-cycle edge pulse
);
   logic [N-1:0] prev_ff; // Previous pin level
   // Sample previous level; resets high so idle-high pins raise nothing
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         prev_ff <= '1;
      end else begin
         prev_ff <= pin;
      end
   end
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_bit
         // Edge seen only while the pin serves as an interrupt input
         assign hit[i] = active[i] & (rise_sel[i] ? (pin[i] & ~prev_ff[i])
                                                 : (~pin[i] & prev_ff[i]));
      end
   endgenerate
endmodule

// file: core/wkint_prio.sv
`timescale 1ns/1ps
`include "wkint_defs.svh"
// Fixed priority vector selection
module wkint_prio
   import wkint_pkg::*;
(
   input wire logic [4:0] req_live,  // Enabled edge request flags
   input wire logic wake_live,       // Any enabled wakeup flag
   input wire logic [2:0] int_live,  // Internal: tfl, tc, ec
   output logic [7:0] vector,        // Selected vector number
   output logic any                  // Some request pending
);
   // Request zero wins; wakeup below all edge pins
   always_comb begin
      vector = `WKINT_VEC_NONE;
      any = 1'b1;
      if (req_live[0]) begin
         vector = `WKINT_VEC_REQ0;
      end else if (req_live[1]) begin
         vector = `WKINT_VEC_REQ0 + 8'h01;
      end else if (req_live[2]) begin
         vector = `WKINT_VEC_REQ0 + 8'h02;
      end else if (req_live[3]) begin
         vector = `WKINT_VEC_REQ0 + 8'h03;
      end else if (req_live[4]) begin
         vector = `WKINT_VEC_REQ0 + 8'h04;
      end else if (wake_live) begin
         vector = `WKINT_VEC_WAKE;
      end else if (int_live[1]) begin
         vector = `WKINT_VEC_TC;
      end else if (int_live[2]) begin
         vector = `WKINT_VEC_TFL;
      end else if (int_live[0]) begin
         vector = `WKINT_VEC_EC;
      end else begin
         any = 1'b0;
      end
   end
endmodule

// file: core/wkint_top.sv
`timescale 1ns/1ps
`include "wkint_defs.svh"
module wkint_top
   import wkint_pkg::*;
(
   input wire logic clk_sys,            // System clock, 25 MHz
   input wire logic rst_n,              // Async reset, active low
   input wire logic psel,               // APB select
   input wire logic penable,            // APB enable
   input wire logic pwrite,             // APB direction
   input wire logic [11:0] paddr,       // APB byte address
   input wire logic [31:0] pwdata,      // APB write data
   output logic [31:0] prdata,          // APB read data
   output logic pready,                 // APB ready
   output logic pslverr,                // APB error
   input wire logic [7:0] wake_pin_n,   // Wakeup pins
   input wire logic [4:0] edge_request_pin_n, // Edge request pins
   input wire wkint_periph_s periph,    // Peripheral event signals
   input wire logic int_accept,         // Core starts exception handling
   output logic int_req,                // Request toward core
   output logic [7:0] int_vector        // Vector of best request
);
   // Register state
   // Flags below are set by hardware and cleared by software only
   logic [4:0] req_flags_ff;       // Edge request flags
   logic [2:0] int_flags_ff;       // Internal flags: tfl, tc, ec
   logic [7:0] wake_flags_ff;      // Wake flags
   // Configuration below is read/write state; the mask is also set on acceptance, vector and read data are read-only
   logic [7:0] wake_edge_ff;       // Wake edge select
   logic [4:0] req_edge_ff;        // Edge request edge select
   logic [7:0] enable_ff;          // Source enable register one
   logic [12:0] pin_mode_ff;       // Pin function select, wake high
   logic mask_ff;                  // Interrupt mask bit
   logic [7:0] vector_ff;          // Registered vector
   logic [31:0] prdata_ff;         // Registered read data
   // Wrap detection history
   logic [7:0] prev_updown_ff;     // Previous up/down count
   logic [7:0] prev_evh_ff;        // Previous event high byte
   logic [7:0] prev_evl_ff;        // Previous event low byte
   // Decoded strobes
   logic wr_acc;                   // Write access phase
   logic rd_setup;                 // Read setup cycle
   logic hit_map;                  // Address is mapped
   logic [4:0] req_hit;            // Edge request pulses
   logic [7:0] wake_hit;           // Wake pulses
   logic [2:0] int_hit;            // Internal set pulses
   logic [7:0] wdat;               // Low write byte
   // Priority and gating
   logic [7:0] vec_sel;            // Selected vector
   logic any_live;                 // Some gated request
   logic [4:0] req_live;           // Enabled edge requests
   logic wake_live;                // Enabled wake group
   logic [2:0] int_live;           // Enabled internal requests

   assign wdat = pwdata[7:0];
   // Writes land at the access edge; there are no wait states
   assign wr_acc = psel & penable & pwrite;
   // Read data is fetched in the setup cycle so it stands through the access
   assign rd_setup = psel & ~penable & ~pwrite;
   // Zero-wait slave; every access finishes in its first access cycle
   assign pready = 1'b1;
   // Address decode; only the nine word addresses answer, the rest error out
   always_comb begin
      unique case (paddr)
         `WKINT_A_FLAGS_ONE, `WKINT_A_FLAGS_TWO, `WKINT_A_WAKE_FLAGS,
         `WKINT_A_WAKE_EDGE, `WKINT_A_REQ_EDGE, `WKINT_A_ENABLE_ONE,
         `WKINT_A_PIN_MODE, `WKINT_A_COND, `WKINT_A_VECTOR: hit_map = 1'b1;
         default: hit_map = 1'b0;
      endcase
   end
   // Unmapped addresses answer with an error, reads give zero
   // A write to an unmapped address changes no state
   assign pslverr = psel & penable & ~hit_map;
   assign prdata = prdata_ff;

   // Edge detectors for both external pin groups
   // Pins are taken as synchronous, so no extra flops and no added latency
   // Mode bits gate each detector, so a pin used as a port never flags
   wkint_edge_det #(.N(8)) u_wake_det (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pin(wake_pin_n),
      .rise_sel(wake_edge_ff),
      .active(pin_mode_ff[12:5]),
      .hit(wake_hit)
   );
   // Five request pins beside eight wake pins make thirteen external sources
   wkint_edge_det #(.N(5)) u_req_det (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pin(edge_request_pin_n),
      .rise_sel(req_edge_ff),
      .active(pin_mode_ff[4:0]),
      .hit(req_hit)
   );

   // Previous counter values for wrap detection
   // Sampled every cycle, so a wrap is judged against the value one cycle old
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         // Reset: counters assumed at zero
         prev_updown_ff <= `WKINT_RST_BYTE;
         prev_evh_ff <= `WKINT_RST_BYTE;
         prev_evl_ff <= `WKINT_RST_BYTE;
      end else begin
         prev_updown_ff <= periph.updown_count;
         prev_evh_ff <= periph.event_count_high;
         prev_evl_ff <= periph.event_count_low;
      end
   end

   // Internal event conditions, judged on the tick of each counter
   always_comb begin
      // Default no event; each bit is then judged on its own tick
      int_hit = 3'b000;
      // Compare match counts only while the low timer runs in 8-bit mode
      int_hit[2] = periph.low_timer_tick & periph.low_timer_8bit_mode &
         (periph.low_timer_counter == periph.low_timer_compare_value);
      // Wrap in either direction; the tick stops a held count from repeating
      int_hit[1] = periph.updown_tick &
         (((prev_updown_ff == `WKINT_CNT_MAX) &&
           (periph.updown_count == `WKINT_CNT_MIN)) ||
          ((prev_updown_ff == `WKINT_CNT_MIN) &&
           (periph.updown_count == `WKINT_CNT_MAX)));
      // Sixteen-bit mode: only the high byte carry out counts
      if (periph.event_16bit_mode) begin
         int_hit[0] = periph.event_tick_high & (prev_evh_ff == `WKINT_CNT_MAX) &
            (periph.event_count_high == `WKINT_CNT_MIN);
      end else begin
         // Eight-bit mode: a wrap of either byte sets the one flag
         int_hit[0] = (periph.event_tick_high & (prev_evh_ff == `WKINT_CNT_MAX) &
            (periph.event_count_high == `WKINT_CNT_MIN)) |
            (periph.event_tick_low & (prev_evl_ff == `WKINT_CNT_MAX) &
            (periph.event_count_low == `WKINT_CNT_MIN));
      end
   end

   // Edge request flags; a zero clears, a one leaves, a set wins
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         // Reset: no request pending
         req_flags_ff <= 5'h00;
      end else if (wr_acc && paddr == `WKINT_A_FLAGS_ONE) begin
         // Zeros clear, ones keep; an edge in the same cycle still sets
         req_flags_ff <= (req_flags_ff & wdat[4:0]) | req_hit;
      end else begin
         // Only hardware sets; taking the interrupt leaves the flag alone
         req_flags_ff <= req_flags_ff | req_hit;
      end
   end

   // Internal flags, same clearing discipline
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         // Reset: no internal event pending
         int_flags_ff <= 3'h0;
      end else if (wr_acc && paddr == `WKINT_A_FLAGS_TWO) begin
         // Zeros clear, ones keep; a counter event in the same cycle still sets
         int_flags_ff <= (int_flags_ff & {wdat[`WKINT_B_TFL], wdat[`WKINT_B_TC],
            wdat[`WKINT_B_EC]}) | int_hit;
      end else begin
         // Flags accumulate until software clears them
         int_flags_ff <= int_flags_ff | int_hit;
      end
   end

   // Wake flags; set even when the group is disabled
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         // Reset: no wake request pending
         wake_flags_ff <= `WKINT_RST_BYTE;
      end else if (wr_acc && paddr == `WKINT_A_WAKE_FLAGS) begin
         // A write can only clear; a wake edge in the same cycle still sets
         wake_flags_ff <= (wake_flags_ff & wdat) | wake_hit;
      end else begin
         // Group enable is not looked at here, so flags record while disabled
         wake_flags_ff <= wake_flags_ff | wake_hit;
      end
   end

   // Plain configuration registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         // Reset: falling edges, all sources off, pins as ports
         wake_edge_ff <= `WKINT_RST_BYTE;
         req_edge_ff <= 5'h00;
         enable_ff <= `WKINT_RST_BYTE;
         pin_mode_ff <= 13'h0000;
      end else if (wr_acc) begin
         // One bit per wake pin: 1 rising, 0 falling
         if (paddr == `WKINT_A_WAKE_EDGE) begin
            wake_edge_ff <= wdat;
         end
         // One bit per request pin, same encoding
         if (paddr == `WKINT_A_REQ_EDGE) begin
            req_edge_ff <= wdat[4:0];
         end
         // Source enables; bits 2..0 are shared with the internal sources
         if (paddr == `WKINT_A_ENABLE_ONE) begin
            enable_ff <= wdat;
         end
         // Pin function; detector history tracks each pin while it is a port, so switching raises no flag
         if (paddr == `WKINT_A_PIN_MODE) begin
            pin_mode_ff <= pwdata[12:0];
         end
      end
   end

   // Mask bit: set at reset, set on acceptance, else software controls it
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         // Reset: masked until software opens the gate
         mask_ff <= `WKINT_RST_MASK;
      end else if (int_accept) begin
         // Acceptance wins over a software write in the same cycle
         mask_ff <= 1'b1;
      end else if (wr_acc && paddr == `WKINT_A_COND) begin
         // Only the mask bit of the written byte is kept
         mask_ff <= wdat[`WKINT_B_MASK];
      end
   end

   // Gating by per-source enables
   // Enable bits 2..0 also gate the internal flags; they share the register
   // The wake group bit gates the OR of all eight flags, not each flag
   assign req_live = req_flags_ff & enable_ff[4:0];
   assign wake_live = (|wake_flags_ff) & enable_ff[`WKINT_B_WAKE_EN];
   assign int_live = int_flags_ff & {enable_ff[`WKINT_B_TFL_EN],
      enable_ff[`WKINT_B_TC_EN], enable_ff[`WKINT_B_EC_EN]};

   // Fixed order keeps the selector small; there is no software priority
   wkint_prio u_prio (
      .req_live(req_live),
      .wake_live(wake_live),
      .int_live(int_live),
      .vector(vec_sel),
      .any(any_live)
   );

   // Request toward the core; the mask holds back all sources
   // Combinational, so the core sees a cleared mask in the next cycle
   assign int_req = any_live & ~mask_ff;

   // Vector register follows the current best request
   // One cycle behind the flags; zero while nothing is pending
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         // Reset: no vector
         vector_ff <= `WKINT_VEC_NONE;
      end else begin
         vector_ff <= vec_sel;
      end
   end
   assign int_vector = vector_ff;

   // Read data captured in the setup cycle; it then stands through the access
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         // Reset: bus reads zero until the first read
         prdata_ff <= 32'h0000_0000;
      end else if (rd_setup) begin
         // Clear the whole word first so unused bits read zero
         prdata_ff <= 32'h0000_0000;
         unique case (paddr)
            `WKINT_A_FLAGS_ONE: begin
               // Reserved bit five is wired to one and ignores writes
               prdata_ff[4:0] <= req_flags_ff;
               prdata_ff[`WKINT_B_FIXED_ONE] <= 1'b1;
            end
            `WKINT_A_FLAGS_TWO: prdata_ff[2:0] <= int_flags_ff;
            `WKINT_A_WAKE_FLAGS: prdata_ff[7:0] <= wake_flags_ff;
            `WKINT_A_WAKE_EDGE: prdata_ff[7:0] <= wake_edge_ff;
            `WKINT_A_REQ_EDGE: prdata_ff[4:0] <= req_edge_ff;
            `WKINT_A_ENABLE_ONE: prdata_ff[7:0] <= enable_ff;
            `WKINT_A_PIN_MODE: prdata_ff[12:0] <= pin_mode_ff;
            `WKINT_A_COND: prdata_ff[`WKINT_B_MASK] <= mask_ff;
            `WKINT_A_VECTOR: prdata_ff[7:0] <= vector_ff;
            // Unmapped: zero data, the error flag tells software
            default: prdata_ff <= 32'h0000_0000;
         endcase
      end
   end
endmodule

// file: test/wkint_top_asserts.sv
`timescale 1ns/1ps
`include "wkint_defs.svh"
// Bus and request checks, seen from the top ports only
module wkint_chk
   import wkint_pkg::*;
(
   input wire logic clk_sys, // System clock
   input wire logic rst_n, // Async reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [11:0] paddr, // APB address
   input wire logic [31:0] pwdata, // APB write data
   input wire logic [31:0] prdata, // APB read data
   input wire logic pready, // APB ready
   input wire logic pslverr, // APB error
   input wire logic [7:0] wake_pin_n, // Wakeup pins
   input wire logic [4:0] edge_request_pin_n, // Edge request pins
   input wire wkint_periph_s periph, // Peripheral events
   input wire logic int_accept, // Core accept pulse
   input wire logic int_req, // Request to core
   input wire logic [7:0] int_vector // Best vector
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Zero wait states, so a stuck ready would hang software
   ready_always_a: assert property (pready) else $error("pready low");
   err_phase_a: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
   err_unmapped_a: assert property (psel && penable && paddr > `WKINT_A_VECTOR
      |-> pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped not refused");
   err_mapped_a: assert property (psel && penable && paddr <= `WKINT_A_VECTOR
      && paddr[1:0] == 2'b00 |-> !pslverr) else $error("mapped refused");
   fixed_one_a: assert property (psel && penable && !pwrite
      && paddr == `WKINT_A_FLAGS_ONE |-> prdata[5] && prdata[31:8] == 24'h0)
      else $error("flags one bit five");
   upper_zero_a: assert property (psel && penable && !pwrite |-> prdata[31:13] == 19'h0)
      else $error("upper read bits set");
   // Mask must hold for the two cycles before any software write could land
   accept_mask_a: assert property (int_accept |=> !int_req ##1 !int_req)
      else $error("request after accept");
   vec_range_a: assert property (int_vector inside {8'h00, [8'h04:8'h0C]})
      else $error("vector out of range");
   req_vec_a: assert property (int_req ##1 int_req |-> int_vector != 8'h00)
      else $error("request without vector");
   // Setting the mask by software silences the request from the next cycle
   mask_write_a: assert property (psel && penable && pwrite && paddr == `WKINT_A_COND
      && pwdata[`WKINT_B_MASK] |=> !int_req) else $error("request while masked");
endmodule
bind wkint_top wkint_chk u_chk (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .wake_pin_n, .edge_request_pin_n, .periph,
   .int_accept, .int_req, .int_vector);

// file: test/wkint_core_model.sv
`timescale 1ns/1ps
// Processor core side: takes a request by pulsing accept once
module wkint_core_model (
   input wire logic clk_sys, // System clock
   input wire logic rst_n, // Async reset, active low
   input wire logic en, // Core accepts requests
   input wire logic int_req, // Request from block
   output logic int_accept // Exception start pulse
);
   logic accept_ff; // Registered accept
   // One pulse per request; the block must mask itself after it
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         accept_ff <= 1'b0;
      end else begin
         accept_ff <= en && int_req && !accept_ff;
      end
   end
   assign int_accept = accept_ff;
endmodule

// file: test/wkint_top_test.sv
`timescale 1ns/1ps
`include "wkint_defs.svh"
// Register and request sequences against the flag block
module wkint_top_test;
   import wkint_pkg::*;
   logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, int_accept, int_req, core_en;
   logic [11:0] paddr; // Bus address
   logic [31:0] pwdata, prdata, rd_data; // Bus data
   logic rd_err; // Last error seen
   logic [7:0] wake_pin_n, int_vector; // Pins and vector
   logic [4:0] edge_request_pin_n; // Request pins
   wkint_periph_s periph; // Peripheral events
   int num_errors, n_compared; // Counters
   wkint_top u_dut (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .wake_pin_n, .edge_request_pin_n, .periph, .int_accept,
      .int_req, .int_vector);
   wkint_core_model u_core (.clk_sys, .rst_n, .en(core_en), .int_req, .int_accept);
   // 25 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   task end_sim();
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask
   // One APB transfer; held until ready is sampled high
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rchk(input string name, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(name, e, rd_data);
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // Hang guard, far beyond the fewer than two hundred cycles the tests need
   initial begin
      #80000;
      num_errors++;
      end_sim();
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata, core_en} = '0;
      wake_pin_n = 8'hFF;
      edge_request_pin_n = 5'h1F;
      periph = '0;
      num_errors = 0;
      n_compared = 0;
      rst_n = 1'b0;
      cyc(5);
      rst_n <= 1'b1;
      rchk("flags one", `WKINT_A_FLAGS_ONE, 32'h20);
      rchk("flags two", `WKINT_A_FLAGS_TWO, 32'h0);
      rchk("wake flags", `WKINT_A_WAKE_FLAGS, 32'h0);
      rchk("wake edge", `WKINT_A_WAKE_EDGE, 32'h0);
      rchk("cond", `WKINT_A_COND, 32'h80);
      apb(1'b0, 12'h040, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, rd_err});
      chk("unmapped data", 32'h0, rd_data);
      $display("test reset and map done");
      // Pins idle high while switched over, so no spurious edge
      wr(`WKINT_A_PIN_MODE, 32'h1FFF);
      wr(`WKINT_A_WAKE_EDGE, 32'h0F);
      wake_pin_n <= 8'h00;
      cyc(3);
      rchk("wake fall", `WKINT_A_WAKE_FLAGS, 32'hF0);
      wake_pin_n <= 8'hFF;
      cyc(3);
      rchk("wake rise", `WKINT_A_WAKE_FLAGS, 32'hFF);
      wr(`WKINT_A_WAKE_FLAGS, 32'hF0);
      rchk("wake clear", `WKINT_A_WAKE_FLAGS, 32'hF0);
      wr(`WKINT_A_ENABLE_ONE, 32'h20);
      core_en <= 1'b1;
      wr(`WKINT_A_COND, 32'h0);
      cyc(4);
      chk("accept vec", 32'h9, int_vector);
      chk("accept req", 32'h0, int_req);
      rchk("accept cond", `WKINT_A_COND, 32'h80);
      rchk("accept keep", `WKINT_A_WAKE_FLAGS, 32'hF0);
      core_en <= 1'b0;
      $display("test wakeup done");
      wr(`WKINT_A_REQ_EDGE, 32'h05);
      edge_request_pin_n <= 5'h00;
      cyc(3);
      edge_request_pin_n <= 5'h1F;
      cyc(3);
      rchk("req flags", `WKINT_A_FLAGS_ONE, 32'h3F);
      wr(`WKINT_A_ENABLE_ONE, 32'h1F);
      // Clear one flag at a time, writing ones to the rest, always while masked
      for (int n = 0; n < 5; n++) begin
         wr(`WKINT_A_COND, 32'h0);
         cyc(2);
         chk("req vec", 32'h4 + n, int_vector);
         chk("req line", 32'h1, int_req);
         wr(`WKINT_A_COND, 32'h80);
         wr(`WKINT_A_FLAGS_ONE, 32'h1F & ~(32'h1 << n));
      end
      wr(`WKINT_A_COND, 32'h0);
      cyc(2);
      chk("group off req", 32'h0, int_req);
      chk("group off vec", 32'h0, int_vector);
      wr(`WKINT_A_COND, 32'h80);
      wr(`WKINT_A_ENABLE_ONE, 32'h20);
      wr(`WKINT_A_COND, 32'h0);
      cyc(2);
      chk("group on req", 32'h1, int_req);
      wr(`WKINT_A_COND, 32'h80);
      cyc(1);
      chk("masked req", 32'h0, int_req);
      wr(`WKINT_A_WAKE_FLAGS, 32'h0);
      rchk("wake zero", `WKINT_A_WAKE_FLAGS, 32'h0);
      $display("test requests done");
      // Compare match, wrap through zero and a 16-bit high byte overflow
      periph.low_timer_8bit_mode <= 1'b1;
      periph.low_timer_counter <= 8'h33;
      periph.low_timer_compare_value <= 8'h33;
      periph.low_timer_tick <= 1'b1;
      periph.updown_count <= 8'hFF;
      periph.updown_tick <= 1'b1;
      periph.event_16bit_mode <= 1'b1;
      periph.event_count_high <= 8'hFF;
      periph.event_tick_high <= 1'b1;
      cyc(1);
      periph.low_timer_tick <= 1'b0;
      periph.updown_count <= 8'h00;
      periph.event_count_high <= 8'h00;
      cyc(1);
      periph.updown_tick <= 1'b0;
      periph.event_tick_high <= 1'b0;
      cyc(2);
      rchk("internal set", `WKINT_A_FLAGS_TWO, 32'h07);
      wr(`WKINT_A_FLAGS_TWO, 32'h0);
      rchk("internal clr", `WKINT_A_FLAGS_TWO, 32'h0);
      // Eight-bit event mode with only the low byte wrapping, and an up/down overflow
      periph.event_16bit_mode <= 1'b0;
      periph.event_count_low <= 8'hFF;
      periph.updown_count <= 8'hFF;
      cyc(1);
      periph.event_count_low <= 8'h00;
      periph.event_tick_low <= 1'b1;
      periph.updown_count <= 8'h00;
      periph.updown_tick <= 1'b1;
      cyc(1);
      periph.event_tick_low <= 1'b0;
      periph.updown_tick <= 1'b0;
      cyc(2);
      rchk("low byte wrap", `WKINT_A_FLAGS_TWO, 32'h03);
      $display("test internal done");
      end_sim();
   end
endmodule
